/* logic/lifb_pkg.sv */
// Constants, source bundle and field layout of the latched flag bank.
// Assumes one system clock and a simple word-wide register port.
// Contract
// - Detectors get rise flags on even bits, fall flags on odd bits, 16..25.
// - Reference-lost rising edge sets loop flag bit 8.
// - Lock rising edge sets bit 0, lock falling edge sets bit 1.
// - Six core error sources latch on rising edges into bits 21..16.
// - Memory-control hardware error rising edge sets bit 31.
// - Four core request lines latch rising edges into bits 3..0.
// - Pin n has rise flag at 14+2n and fall flag at 15+2n.
// - Event-log full rising edge sets bit 16.
// - Trace stack error sets bit 3; profiler done events set bits 1, 0.
// - Serial master stall sets bit 3, block bit 1, done bit 0.
// - Two timers latch rising edges into bits 16 and 17.
// - Alarm channels one to four latch into bits 0 to 3.
// - Live bit 10 shows the system clock is too slow.
// - Bit 3 shows boot finished; host waits for it before writing.
// - Live detector bits read 1 while a signal is detected.
// - Live loop bits: 8 reference lost, 0 locked.
// - Live core bits: watchdog 20, bus system, bus packing, nonmaskable.
// - Live bits 3..0 mirror the four core request lines.
// - Pin levels read on even bits 16..30, only for plain inputs.
// - Live bit 16 reads 1 while the event-log FIFO is full.
// - Each flag has a mask bit at the same position; 1 masks it.
// - Flags stay set until written with 1; request holds until cleared.
// - Request is the OR of all unmasked flags.
// - Masked flags still latch and read back but never raise request.
// - Each pin flag has a trigger-type bit: 0 level, 1 edge, reset 0.
`default_nettype none

package lifb_pkg;

  // ==========================================================
  // Register map
  localparam int NFLAG = 10;
  localparam int IDX_DET = 0;
  localparam int IDX_LOOP = 1;
  localparam int IDX_CORE_ERR = 2;
  localparam int IDX_CORE_REQ = 3;
  localparam int IDX_PIN = 4;
  localparam int IDX_EVLOG = 5;
  localparam int IDX_TRACE = 6;
  localparam int IDX_SERIAL = 7;
  localparam int IDX_TIMER = 8;
  localparam int IDX_ALARM = 9;
  localparam logic [17:0] FLAG_OFS [NFLAG] = '{
    18'h18020, 18'h18024, 18'h18028, 18'h18030, 18'h18038,
    18'h1803c, 18'h18040, 18'h18048, 18'h18050, 18'h18054};
  // Implemented flag bits per register; the rest read as zero
  localparam logic [31:0] FLAG_IMPL [NFLAG] = '{
    32'h03ff0000, 32'h00000103, 32'h003f0000, 32'h8000000f, 32'hffff0000,
    32'h00010000, 32'h0000000b, 32'h0000000b, 32'h00030000, 32'h0000000f};
  localparam logic [17:0] MASK_DELTA = 18'h00100;
  localparam logic [17:0] OFS_CLK_STS = 18'h18090;
  localparam logic [17:0] OFS_BOOT_STS = 18'h18094;
  localparam logic [17:0] OFS_DET_STS = 18'h180a0;
  localparam logic [17:0] OFS_LOOP_STS = 18'h180a4;
  localparam logic [17:0] OFS_CORE_ERR_STS = 18'h180a8;
  localparam logic [17:0] OFS_CORE_REQ_STS = 18'h180b0;
  localparam logic [17:0] OFS_PIN_STS = 18'h180b8;
  localparam logic [17:0] OFS_EVLOG_STS = 18'h180bc;
  localparam logic [17:0] OFS_PIN_TYPE = 18'h18238;

  // ==========================================================
  // Field positions
  localparam int DET_BASE = 16;
  localparam int REF_LOST_BIT = 8;
  localparam int LOCK_RISE_BIT = 0;
  localparam int LOCK_FALL_BIT = 1;
  localparam int CORE_ERR_BASE = 16;
  localparam int MEM_ERR_BIT = 31;
  localparam int CORE_REQ_BASE = 0;
  localparam int PIN_BASE = 16;
  localparam int FULL_BIT = 16;
  localparam int TRACE_BIT = 3;
  localparam int PROF_BASE = 0;
  localparam int STALL_BIT = 3;
  localparam int BLOCK_BIT = 1;
  localparam int DONE_BIT = 0;
  localparam int TIMER_BASE = 16;
  localparam int ALARM_BASE = 0;
  localparam int SHORT_BIT = 10;
  localparam int BOOT_BIT = 3;
  localparam int NPIN = 8;

  // ==========================================================
  // Reset values
  localparam logic [31:0] FLAG_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = 32'hffffffff;
  localparam logic [31:0] TYPE_RESET = 32'h00000000;

  // Event and status sources, all on the system clock
  typedef struct packed {
    logic [4:0] detect;    // 0 dyn a,1 dyn b,2 input,3 ultra a,4 ultra b
    logic ref_lost;
    logic locked;
    logic [5:0] core_err;  // 0 nmi,1 pack,2 sys,3 memctl,4 wdog,5 protect
    logic mem_ctrl_err;
    logic [3:0] core_req;
    logic event_full;
    logic trace_err;
    logic [1:0] prof_done;
    logic stall;
    logic block;
    logic done;
    logic [1:0] timer;
    logic [3:0] alarm;
    logic clk_short;
    logic boot_done;
  } lifb_src_t;

endpackage : lifb_pkg

`default_nettype wire

/* logic/lifb_top.sv */
// Latched event flag bank with masks, live status and request output.
// Assumes sources are synchronous to clk except the pins, which are raw.
`default_nettype none

module lifb_top (
  input wire logic clk,
  input wire logic rst,
  input wire lifb_pkg::lifb_src_t src,
  input wire logic [7:0] pin_level,
  input wire logic [7:0] pin_is_input,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [17:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic request_output
);

  // ==========================================================
  // Pin synchroniser
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;

  // Raw pins are asynchronous; only the second stage is read
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= pin_level;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ==========================================================
  // Trigger vectors
  logic [31:0] trig [lifb_pkg::NFLAG];
  logic [31:0] prev_reg [lifb_pkg::NFLAG];
  logic [31:0] level_mode [lifb_pkg::NFLAG];
  logic [31:0] type_reg;
  logic prime_reg;

  // Fall flags see an inverted level so every flag is a rising trigger
  always_comb begin
    for (int k = 0; k < lifb_pkg::NFLAG; k++) begin
      trig[k] = 32'h00000000;
      level_mode[k] = 32'h00000000;
    end
    for (int i = 0; i < 5; i++) begin
      trig[lifb_pkg::IDX_DET][lifb_pkg::DET_BASE + 2 * i] = src.detect[i];
      trig[lifb_pkg::IDX_DET][lifb_pkg::DET_BASE + 2 * i + 1] = ~src.detect[i];
    end
    trig[lifb_pkg::IDX_LOOP][lifb_pkg::REF_LOST_BIT] = src.ref_lost;
    trig[lifb_pkg::IDX_LOOP][lifb_pkg::LOCK_RISE_BIT] = src.locked;
    trig[lifb_pkg::IDX_LOOP][lifb_pkg::LOCK_FALL_BIT] = ~src.locked;
    for (int i = 0; i < 6; i++) begin
      trig[lifb_pkg::IDX_CORE_ERR][lifb_pkg::CORE_ERR_BASE + i] = src.core_err[i];
    end
    trig[lifb_pkg::IDX_CORE_REQ][lifb_pkg::MEM_ERR_BIT] = src.mem_ctrl_err;
    for (int i = 0; i < 4; i++) begin
      trig[lifb_pkg::IDX_CORE_REQ][lifb_pkg::CORE_REQ_BASE + i] = src.core_req[i];
      trig[lifb_pkg::IDX_ALARM][lifb_pkg::ALARM_BASE + i] = src.alarm[i];
    end
    for (int i = 0; i < lifb_pkg::NPIN; i++) begin
      trig[lifb_pkg::IDX_PIN][lifb_pkg::PIN_BASE + 2 * i] = pin_s2_reg[i];
      trig[lifb_pkg::IDX_PIN][lifb_pkg::PIN_BASE + 2 * i + 1] = ~pin_s2_reg[i];
    end
    trig[lifb_pkg::IDX_EVLOG][lifb_pkg::FULL_BIT] = src.event_full;
    trig[lifb_pkg::IDX_TRACE][lifb_pkg::TRACE_BIT] = src.trace_err;
    trig[lifb_pkg::IDX_TRACE][lifb_pkg::PROF_BASE] = src.prof_done[0];
    trig[lifb_pkg::IDX_TRACE][lifb_pkg::PROF_BASE + 1] = src.prof_done[1];
    trig[lifb_pkg::IDX_SERIAL][lifb_pkg::STALL_BIT] = src.stall;
    trig[lifb_pkg::IDX_SERIAL][lifb_pkg::BLOCK_BIT] = src.block;
    trig[lifb_pkg::IDX_SERIAL][lifb_pkg::DONE_BIT] = src.done;
    trig[lifb_pkg::IDX_TIMER][lifb_pkg::TIMER_BASE] = src.timer[0];
    trig[lifb_pkg::IDX_TIMER][lifb_pkg::TIMER_BASE + 1] = src.timer[1];
    // Type 0 means level: the flag keeps re-setting while the level holds
    level_mode[lifb_pkg::IDX_PIN] = ~type_reg;
  end

  // Edge detection waits one cycle after reset so levels are not taken as edges
  always_ff @(posedge clk) begin
    if (rst) begin
      prime_reg <= 1'b0;
    end else begin
      prime_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Address decode
  logic [lifb_pkg::NFLAG-1:0] hit_flag;
  logic [lifb_pkg::NFLAG-1:0] hit_mask;
  logic hit_type;

  // One compare per flag register and its mask twin
  always_comb begin
    for (int k = 0; k < lifb_pkg::NFLAG; k++) begin
      hit_flag[k] = (reg_addr == lifb_pkg::FLAG_OFS[k]);
      hit_mask[k] = (reg_addr == lifb_pkg::FLAG_OFS[k] + lifb_pkg::MASK_DELTA);
    end
    hit_type = (reg_addr == lifb_pkg::OFS_PIN_TYPE);
  end

  // ==========================================================
  // Flags and masks
  logic [31:0] flag_reg [lifb_pkg::NFLAG];
  logic [31:0] mask_reg [lifb_pkg::NFLAG];
  logic [31:0] pend [lifb_pkg::NFLAG];

  genvar g;
  generate
    for (g = 0; g < lifb_pkg::NFLAG; g++) begin : g_flag
      logic [31:0] set_vec;
      logic [31:0] clr_vec;
      logic [31:0] flag_next;

      // Set wins over a write-one clear landing in the same cycle
      always_comb begin
        set_vec = prime_reg ? (trig[g] & (~prev_reg[g] | level_mode[g])) : 32'h00000000;
        clr_vec = (reg_wr && hit_flag[g]) ? reg_wdata : 32'h00000000;
        flag_next = ((flag_reg[g] & ~clr_vec) | set_vec) & lifb_pkg::FLAG_IMPL[g];
        pend[g] = flag_reg[g] & ~mask_reg[g];
      end

      // Latched flags and last-seen trigger levels
      always_ff @(posedge clk) begin
        if (rst) begin
          flag_reg[g] <= lifb_pkg::FLAG_RESET;
          prev_reg[g] <= 32'h00000000;
        end else begin
          flag_reg[g] <= flag_next;
          prev_reg[g] <= trig[g];
        end
      end

      // Masks default to masked so nothing here raises request at power-up
      always_ff @(posedge clk) begin
        if (rst) begin
          mask_reg[g] <= lifb_pkg::MASK_RESET & lifb_pkg::FLAG_IMPL[g];
        end else if (reg_wr && hit_mask[g]) begin
          mask_reg[g] <= reg_wdata & lifb_pkg::FLAG_IMPL[g];
        end
      end
    end
  endgenerate

  // Trigger type for the pin flags
  always_ff @(posedge clk) begin
    if (rst) begin
      type_reg <= lifb_pkg::TYPE_RESET;
    end else if (reg_wr && hit_type) begin
      type_reg <= reg_wdata & lifb_pkg::FLAG_IMPL[lifb_pkg::IDX_PIN];
    end
  end

  // ==========================================================
  // Request output
  logic pend_any;

  // Request lags the flags by one cycle, traded for a clean flop output
  always_comb begin
    pend_any = 1'b0;
    for (int k = 0; k < lifb_pkg::NFLAG; k++) begin
      pend_any = pend_any | (|pend[k]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      request_output <= 1'b0;
    end else begin
      request_output <= pend_any;
    end
  end

  // ==========================================================
  // Read path
  logic [31:0] rd_next;

  // Live status is sampled on the read; writes to it have no target
  always_comb begin
    rd_next = 32'h00000000;
    for (int k = 0; k < lifb_pkg::NFLAG; k++) begin
      if (hit_flag[k]) begin
        rd_next = flag_reg[k];
      end
      if (hit_mask[k]) begin
        rd_next = mask_reg[k];
      end
    end
    if (hit_type) begin
      rd_next = type_reg;
    end
    case (reg_addr)
      lifb_pkg::OFS_CLK_STS: begin
        rd_next[lifb_pkg::SHORT_BIT] = src.clk_short;
      end
      lifb_pkg::OFS_BOOT_STS: begin
        rd_next[lifb_pkg::BOOT_BIT] = src.boot_done;
      end
      lifb_pkg::OFS_DET_STS: begin
        for (int i = 0; i < 5; i++) begin
          rd_next[lifb_pkg::DET_BASE + 2 * i] = src.detect[i];
        end
      end
      lifb_pkg::OFS_LOOP_STS: begin
        rd_next[lifb_pkg::REF_LOST_BIT] = src.ref_lost;
        rd_next[lifb_pkg::LOCK_RISE_BIT] = src.locked;
      end
      lifb_pkg::OFS_CORE_ERR_STS: begin
        rd_next[lifb_pkg::CORE_ERR_BASE + 4] = src.core_err[4];
        rd_next[lifb_pkg::CORE_ERR_BASE + 2] = src.core_err[2];
        rd_next[lifb_pkg::CORE_ERR_BASE + 1] = src.core_err[1];
        rd_next[lifb_pkg::CORE_ERR_BASE] = src.core_err[0];
      end
      lifb_pkg::OFS_CORE_REQ_STS: begin
        rd_next[3:0] = src.core_req;
      end
      lifb_pkg::OFS_PIN_STS: begin
        for (int i = 0; i < lifb_pkg::NPIN; i++) begin
          rd_next[lifb_pkg::PIN_BASE + 2 * i] = pin_s2_reg[i] & pin_is_input[i];
        end
      end
      lifb_pkg::OFS_EVLOG_STS: begin
        rd_next[lifb_pkg::FULL_BIT] = src.event_full;
      end
      default: begin
      end
    endcase
  end

  // Read data answers one cycle after the strobe and holds until the next
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_next;
      end
    end
  end

  // ==========================================================
  // Checks
  property p_ref_lost_edge;
    @(posedge clk) disable iff (rst)
    prime_reg && src.ref_lost && !$past(src.ref_lost)
      |=> flag_reg[lifb_pkg::IDX_LOOP][lifb_pkg::REF_LOST_BIT];
  endproperty
  a_ref_lost_edge: assert property (p_ref_lost_edge)
    else $error("reference-lost edge not latched");

  property p_lock_fall;
    @(posedge clk) disable iff (rst)
    prime_reg && !src.locked && $past(src.locked)
      |=> flag_reg[lifb_pkg::IDX_LOOP][lifb_pkg::LOCK_FALL_BIT];
  endproperty
  a_lock_fall: assert property (p_lock_fall)
    else $error("lock fall not latched");

  property p_sticky;
    @(posedge clk) disable iff (rst)
    flag_reg[lifb_pkg::IDX_TIMER][lifb_pkg::TIMER_BASE]
      && !(reg_wr && hit_flag[lifb_pkg::IDX_TIMER])
      |=> flag_reg[lifb_pkg::IDX_TIMER][lifb_pkg::TIMER_BASE];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("timer flag dropped without a clear");

  property p_clear;
    @(posedge clk) disable iff (rst)
    reg_wr && hit_flag[lifb_pkg::IDX_ALARM] && reg_wdata[0] && !src.alarm[0]
      |=> !flag_reg[lifb_pkg::IDX_ALARM][lifb_pkg::ALARM_BASE];
  endproperty
  a_clear: assert property (p_clear)
    else $error("write one did not clear alarm flag");

  property p_request_or;
    @(posedge clk) disable iff (rst)
    1'b1 |=> request_output == $past(pend_any);
  endproperty
  a_request_or: assert property (p_request_or)
    else $error("request differs from unmasked flags");

  property p_masked_quiet;
    @(posedge clk) disable iff (rst)
    (mask_reg[lifb_pkg::IDX_PIN] == 32'hffff0000) && !pend_any
      && (flag_reg[lifb_pkg::IDX_PIN] != 32'h00000000) |=> !request_output;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked pin flag raised request");

  property p_pin_level;
    @(posedge clk) disable iff (rst)
    prime_reg && pin_s2_reg[0] && !type_reg[lifb_pkg::PIN_BASE]
      |=> flag_reg[lifb_pkg::IDX_PIN][lifb_pkg::PIN_BASE];
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("level mode pin flag not set");

  property p_loop_read;
    @(posedge clk) disable iff (rst)
    reg_rd && reg_addr == lifb_pkg::OFS_LOOP_STS
      |=> reg_rvalid && reg_rdata[lifb_pkg::LOCK_RISE_BIT] == $past(src.locked);
  endproperty
  a_loop_read: assert property (p_loop_read)
    else $error("loop status read wrong");

  property p_reset_clear;
    @(posedge clk)
    rst |=> flag_reg[lifb_pkg::IDX_DET] == 32'h00000000 && type_reg == 32'h00000000
      && !request_output;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  property p_det_fall;
    @(posedge clk) disable iff (rst)
    prime_reg && !src.detect[4] && $past(src.detect[4])
      |=> flag_reg[lifb_pkg::IDX_DET][lifb_pkg::DET_BASE + 9];
  endproperty
  a_det_fall: assert property (p_det_fall)
    else $error("top detector fall flag not latched");

  property p_mem_err;
    @(posedge clk) disable iff (rst)
    prime_reg && src.mem_ctrl_err && !$past(src.mem_ctrl_err)
      |=> flag_reg[lifb_pkg::IDX_CORE_REQ][lifb_pkg::MEM_ERR_BIT];
  endproperty
  a_mem_err: assert property (p_mem_err)
    else $error("memory control error not latched");

  property p_pin_fall;
    @(posedge clk) disable iff (rst)
    prime_reg && !pin_s2_reg[7] && $past(pin_s2_reg[7])
      |=> flag_reg[lifb_pkg::IDX_PIN][lifb_pkg::PIN_BASE + 15];
  endproperty
  a_pin_fall: assert property (p_pin_fall)
    else $error("last pin fall flag not latched");

  property p_full_edge;
    @(posedge clk) disable iff (rst)
    prime_reg && src.event_full && !$past(src.event_full)
      |=> flag_reg[lifb_pkg::IDX_EVLOG][lifb_pkg::FULL_BIT];
  endproperty
  a_full_edge: assert property (p_full_edge)
    else $error("event log full edge not latched");

  property p_timer_edge;
    @(posedge clk) disable iff (rst)
    prime_reg && src.timer[1] && !$past(src.timer[1])
      |=> flag_reg[lifb_pkg::IDX_TIMER][lifb_pkg::TIMER_BASE + 1];
  endproperty
  a_timer_edge: assert property (p_timer_edge)
    else $error("second timer edge not latched");

  property p_req_read;
    @(posedge clk) disable iff (rst)
    reg_rd && reg_addr == lifb_pkg::OFS_CORE_REQ_STS
      |=> reg_rvalid && reg_rdata[3:0] == $past(src.core_req);
  endproperty
  a_req_read: assert property (p_req_read)
    else $error("core request status read wrong");

  property p_pin_read;
    @(posedge clk) disable iff (rst)
    reg_rd && reg_addr == lifb_pkg::OFS_PIN_STS
      |=> reg_rdata[lifb_pkg::PIN_BASE] == ($past(pin_s2_reg[0]) & $past(pin_is_input[0]));
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("first pin level read wrong");

endmodule : lifb_top

`default_nettype wire

/* bench/lifb_host.sv */
// Host model: drives the register port of the flag bank and polls it.
// Assumes one shared clock; strobes change only after a falling edge.
`default_nettype none

module lifb_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [17:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic request_output
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 18'h00000;
    reg_wdata = 32'h00000000;
  end

  // ==========================================================
  // Bus cycles
  // Released lines carry the inverse so stale values never look valid
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // Data is taken where the valid pulse stands
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask : rd

  // Polls the boot bit; no write may come before it reads 1
  task automatic wait_boot(output logic ok);
    logic [31:0] d;
    logic v;
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      rd(18'h18094, d, v);
      ok = (d[3] === 1'b1);
    end
  endtask : wait_boot

endmodule : lifb_host

`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the latched flag bank.
// Assumes lifb_pkg and lifb_top compiled first; host model drives the port.
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] k;
    logic [17:0] fo;
    logic [31:0] fe;
    logic [17:0] so;
    logic [31:0] se;
  } lifb_row_t;

  // Source bit, flag word after a pulse, live word while high
  localparam int NROW = 25;
  localparam lifb_row_t ROWS [NROW] = '{
    '{8'h1c, 18'h18020, 32'h00030000, 18'h180a0, 32'h00010000},
    '{8'h1e, 18'h18020, 32'h00300000, 18'h180a0, 32'h00100000},
    '{8'h20, 18'h18020, 32'h03000000, 18'h180a0, 32'h01000000},
    '{8'h1b, 18'h18024, 32'h00000100, 18'h180a4, 32'h00000100},
    '{8'h1a, 18'h18024, 32'h00000003, 18'h180a4, 32'h00000001},
    '{8'h14, 18'h18028, 32'h00010000, 18'h180a8, 32'h00010000},
    '{8'h16, 18'h18028, 32'h00040000, 18'h180a8, 32'h00040000},
    '{8'h17, 18'h18028, 32'h00080000, 18'h180a8, 32'h00000000},
    '{8'h18, 18'h18028, 32'h00100000, 18'h180a8, 32'h00100000},
    '{8'h19, 18'h18028, 32'h00200000, 18'h180a8, 32'h00000000},
    '{8'h13, 18'h18030, 32'h80000000, 18'h180b0, 32'h00000000},
    '{8'h0f, 18'h18030, 32'h00000001, 18'h180b0, 32'h00000001},
    '{8'h12, 18'h18030, 32'h00000008, 18'h180b0, 32'h00000008},
    '{8'h0e, 18'h1803c, 32'h00010000, 18'h180bc, 32'h00010000},
    '{8'h0d, 18'h18040, 32'h00000008, 18'h00000, 32'h00000000},
    '{8'h0b, 18'h18040, 32'h00000001, 18'h00000, 32'h00000000},
    '{8'h0c, 18'h18040, 32'h00000002, 18'h00000, 32'h00000000},
    '{8'h0a, 18'h18048, 32'h00000008, 18'h00000, 32'h00000000},
    '{8'h09, 18'h18048, 32'h00000002, 18'h00000, 32'h00000000},
    '{8'h08, 18'h18048, 32'h00000001, 18'h00000, 32'h00000000},
    '{8'h06, 18'h18050, 32'h00010000, 18'h00000, 32'h00000000},
    '{8'h07, 18'h18050, 32'h00020000, 18'h00000, 32'h00000000},
    '{8'h02, 18'h18054, 32'h00000001, 18'h00000, 32'h00000000},
    '{8'h05, 18'h18054, 32'h00000008, 18'h00000, 32'h00000000},
    '{8'h01, 18'h00000, 32'h00000000, 18'h18090, 32'h00000400}};
  localparam int SW = $bits(lifb_pkg::lifb_src_t);

  logic clk;
  logic rst;
  lifb_pkg::lifb_src_t src;
  logic [SW-1:0] sv;
  logic [7:0] pin_level;
  logic [7:0] pin_is_input;
  logic reg_wr;
  logic reg_rd;
  logic [17:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic request_output;
  logic ok;
  lifb_row_t r;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  lifb_top u_dut (
    .clk(clk),
    .rst(rst),
    .src(src),
    .pin_level(pin_level),
    .pin_is_input(pin_is_input),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .request_output(request_output)
  );

  lifb_host u_host (
    .clk(clk),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .request_output(request_output)
  );

  // ==========================================================
  // Clock, timeout and helpers
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole plan needs under a thousand cycles; a hang ends the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH t=%0t timeout after %0d cycles", $time, cycles);
      conclude();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Read with valid pulse and data compared
  task automatic rdc(input logic [17:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic v;
    u_host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask : rdc

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    src = '0;
    pin_level = 8'h80;
    pin_is_input = 8'h01;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    // Reset values, unmapped read, boot wait
    rdc(18'h18238, 32'h00000000);
    rdc(18'h18120, 32'h03ff0000);
    rdc(18'h18024, 32'h00000000);
    rdc(18'h18000, 32'h00000000);
    rdc(18'h18094, 32'h00000000);
    `CHK(request_output, 1'b0)
    sv = '0;
    sv[0] = 1'b1;
    src = sv;
    u_host.wait_boot(ok);
    `CHK(ok, 1'b1)
    $display("test reset done");
    // One pulse per row of ROWS: live bit, latch, mask, clear
    for (int i = 0; i < NROW; i++) begin
      r = ROWS[i];
      sv[r.k] = 1'b1;
      src = sv;
      cyc(4);
      if (r.so != 18'h00000) begin
        // Write to a live register must not stick
        u_host.wr(r.so, 32'hffffffff);
        rdc(r.so, r.se);
      end
      sv = '0;
      sv[0] = 1'b1;
      src = sv;
      cyc(4);
      if (r.fo != 18'h00000) begin
        rdc(r.fo, r.fe);
        `CHK(request_output, 1'b0)
        u_host.wr(r.fo + 18'h00100, 32'h00000000);
        cyc(2);
        `CHK(request_output, 1'b1)
        u_host.wr(r.fo, 32'hffffffff);
        cyc(2);
        `CHK(request_output, 1'b0)
        rdc(r.fo, 32'h00000000);
        u_host.wr(r.fo + 18'h00100, 32'hffffffff);
      end
    end
    $display("test sources done");
    // Pins in edge mode: pin 1 rises, pin 8 falls
    u_host.wr(18'h18238, 32'hffffffff);
    rdc(18'h18238, 32'hffff0000);
    u_host.wr(18'h18038, 32'hffffffff);
    rdc(18'h18038, 32'h00000000);
    pin_level = 8'h01;
    cyc(6);
    rdc(18'h18038, 32'h80010000);
    rdc(18'h180b8, 32'h00010000);
    pin_is_input = 8'h00;
    rdc(18'h180b8, 32'h00000000);
    // Level mode on pin 1 rise: flag comes back after a clear
    u_host.wr(18'h18238, 32'hfffe0000);
    u_host.wr(18'h18038, 32'hffffffff);
    cyc(2);
    rdc(18'h18038, 32'h00010000);
    u_host.wr(18'h18138, 32'hfffeffff);
    cyc(2);
    `CHK(request_output, 1'b1)
    u_host.wr(18'h18038, 32'hffffffff);
    cyc(2);
    `CHK(request_output, 1'b1)
    $display("test pins done");
    // Second reset in mid-run restores masks and types
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
    `CHK(request_output, 1'b0)
    rdc(18'h18238, 32'h00000000);
    rdc(18'h18138, 32'hffff0000);
    $display("test rerun reset done");
    conclude();
  end

endmodule : tb

`undef CHK

`default_nettype wire
